// ===== logic/pdt_pkg.sv
// constants for the prescaled down-counter timer
package pdt_pkg;
  // =====================================
  // register indices, byte address is index times four
  localparam logic [7:0] IDX_COUNT = 8'h08;
  localparam logic [7:0] IDX_CTL = 8'h09;
  localparam logic [7:0] IDX_STS = 8'h0A;
  localparam logic [7:0] IDX_CLR = 8'h0B;
  localparam logic [7:0] IDX_EN = 8'h0C;
  // =====================================
  // control register fields
  localparam int CTL_FLAG = 7;
  localparam int CTL_MASK = 6;
  localparam int CTL_PCLR = 3;
  localparam logic [7:0] CTL_UNUSED_RD = 8'h37;
  localparam logic CTL_MASK_RST = 1'b1;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  // =====================================
  // event bits of status, clear and enable registers
  localparam int EVT_ZERO = 0;
  localparam int EVT_WRAP = 1;
  localparam int EVT_W = 2;
  // =====================================
  // prescaler and pin path
  localparam int PRESC_W = 7;
  localparam int PIN_LAT_CYC = 3;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // =====================================
  // interrupt service sequence
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_STACK = 2'b01,
    SEQ_VECTOR = 2'b11,
    SEQ_RUN = 2'b10
  } pdt_seq_t;
endpackage : pdt_pkg

// ===== logic/pdt_timer.sv
// prescaled 8-bit down-counter timer with apb registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
// =====================================
// Operation
// - loadable 8-bit count, decrements per prescaler tick
// - 7-bit divider, build-time division up to 128
// - reaching zero sets control bit 7 flag
// - control bit 6 masks request toward processor
// - processor takes request only with global mask clear
// - take: stack state, fetch vector, run service
// - flag clears on reset or zero write; mask resets high
// - writing bit 3 clears prescaler; reads zero
// - count wraps from zero to ff, continues
// - count readable anytime without disturbing counting
// - pin rise advances prescaler after three cycles
// - clock source fixed at build time
// - control bits 5, 4 and 2 to 0 have no function
// - request raised on step from one to zero
// - cleared flag leaves no latched request
// - external interrupt served before timer interrupt
module pdt_timer #(
  parameter bit USE_EXT_PIN = 1'b0,
  parameter logic [2:0] PRESCALE_SEL = 3'd0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin,
  input wire logic insn_end,
  input wire logic global_mask,
  input wire logic ext_irq_pend,
  input wire logic service_done,
  output logic timer_req,
  output logic ext_take,
  output logic stack_save,
  output logic vector_fetch,
  output logic service_run,
  output logic irq
);
  import pdt_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == {idx[5:0], 2'b00});
  endfunction : hit

  // =====================================
  // apb decode
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_reg;
  wire h_cnt = hit(paddr, IDX_COUNT);
  wire h_ctl = hit(paddr, IDX_CTL);
  wire h_sts = hit(paddr, IDX_STS);
  wire h_clr = hit(paddr, IDX_CLR);
  wire h_en = hit(paddr, IDX_EN);
  wire h_any = h_cnt | h_ctl | h_sts | h_clr | h_en;
  wire wr = acc & pwrite;
  wire wr_cnt = wr & h_cnt;
  wire wr_ctl = wr & h_ctl;
  wire wr_clr = wr & h_clr;
  wire wr_en = wr & h_en;

  // =====================================
  // clock source and pin synchroniser
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_s3_reg;
  // pin edge seen two edges after change, so the prescaler moves on the third
  wire ext_tick = pin_s2_reg & ~pin_s3_reg;
  // a low pin gates the internal clock off
  wire int_tick = pin_s2_reg;
  wire in_tick = USE_EXT_PIN ? ext_tick : int_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= timer_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // =====================================
  // prescaler
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  wire [PRESC_W-1:0] presc_sel = PRESC_W'((8'h01 << PRESCALE_SEL) - 8'h01);
  wire pclr = wr_ctl & pwdata[CTL_PCLR];
  wire ps_tick = in_tick & ((presc_reg & presc_sel) == presc_sel);
  assign presc_next = pclr ? '0 : (in_tick ? presc_reg + 1'b1 : presc_reg);

  // =====================================
  // counter and flag
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic flag_reg;
  logic flag_next;
  logic mask_reg;
  logic mask_next;
  wire step = ps_tick & ~wr_cnt;
  wire zero_evt = step & (cnt_reg == COUNT_ONE);
  wire wrap_evt = step & (cnt_reg == COUNT_RST);
  // wraps through ff naturally by modular subtraction
  assign cnt_next = wr_cnt ? pwdata[7:0] : (step ? cnt_reg - 8'h01 : cnt_reg);
  // set wins over a software clear in the same cycle
  assign flag_next = zero_evt | (flag_reg & ~(wr_ctl & ~pwdata[CTL_FLAG]));
  assign mask_next = wr_ctl ? pwdata[CTL_MASK] : mask_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= '0;
      cnt_reg <= COUNT_RST;
      flag_reg <= 1'b0;
      mask_reg <= CTL_MASK_RST;
    end else begin
      presc_reg <= presc_next;
      cnt_reg <= cnt_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
    end
  end

  // =====================================
  // event status, enable, interrupt line
  logic [EVT_W-1:0] sts_reg;
  logic [EVT_W-1:0] sts_next;
  logic [EVT_W-1:0] en_reg;
  logic [EVT_W-1:0] en_next;
  logic irq_reg;
  wire [EVT_W-1:0] evt = {wrap_evt, zero_evt};
  assign sts_next = evt | (sts_reg & ~(wr_clr ? pwdata[EVT_W-1:0] : '0));
  assign en_next = wr_en ? pwdata[EVT_W-1:0] : en_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_reg <= '0;
      en_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      en_reg <= en_next;
      irq_reg <= |(sts_next & en_next);
    end
  end

  // =====================================
  // register read and bus answer
  // bit 3 always reads zero so read-modify-write never clears the prescaler
  wire [7:0] ctl_rd = {flag_reg, mask_reg, 6'b00_0000} | CTL_UNUSED_RD;
  wire [31:0] rd_mux =
    h_cnt ? {24'h00_0000, cnt_reg} :
    h_ctl ? {24'h00_0000, ctl_rd} :
    h_sts ? {30'h0000_0000, sts_reg} :
    h_en ? {30'h0000_0000, en_reg} : DATA_ZERO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= DATA_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      prdata_reg <= (setup & ~pwrite) ? rd_mux : DATA_ZERO;
      pslverr_reg <= setup & ~h_any;
    end
  end

  // =====================================
  // processor-side interrupt acceptance
  pdt_seq_t seq_reg;
  pdt_seq_t seq_next;
  logic timer_req_reg;
  logic ext_take_reg;
  // request follows the flag directly, nothing else latches it
  wire treq = flag_reg & ~mask_reg;
  wire decide = insn_end & (seq_reg == SEQ_IDLE) & ~global_mask;
  wire take_ext = decide & ext_irq_pend;
  wire take_tmr = decide & ~ext_irq_pend & treq;

  always_comb begin
    case (seq_reg)
      SEQ_IDLE: seq_next = take_tmr ? SEQ_STACK : SEQ_IDLE;
      SEQ_STACK: seq_next = SEQ_VECTOR;
      SEQ_VECTOR: seq_next = SEQ_RUN;
      SEQ_RUN: seq_next = service_done ? SEQ_IDLE : SEQ_RUN;
      default: seq_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SEQ_IDLE;
      timer_req_reg <= 1'b0;
      ext_take_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      timer_req_reg <= flag_next & ~mask_next;
      ext_take_reg <= take_ext;
    end
  end

  logic stack_reg;
  logic vect_reg;
  logic run_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_reg <= 1'b0;
      vect_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      stack_reg <= (seq_next == SEQ_STACK);
      vect_reg <= (seq_next == SEQ_VECTOR);
      run_reg <= (seq_next == SEQ_RUN);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_req = timer_req_reg;
  assign ext_take = ext_take_reg;
  assign stack_save = stack_reg;
  assign vector_fetch = vect_reg;
  assign service_run = run_reg;
  assign irq = irq_reg;

  // =====================================
  // assertions
  property p_dec;
    @(posedge pclk) disable iff (!presetn)
    step |=> cnt_reg == 8'($past(cnt_reg) - 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("count did not step down");

  property p_presc_clr;
    @(posedge pclk) disable iff (!presetn)
    pclr |=> presc_reg == '0;
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

  property p_rd_bit3;
    @(posedge pclk) disable iff (!presetn)
    setup & ~pwrite & h_ctl |=> pready_reg & ~prdata_reg[CTL_PCLR] & (prdata_reg[5:4] == 2'b11);
  endproperty
  a_rd_bit3: assert property (p_rd_bit3) else $error("control read wrong");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
    step & (cnt_reg == COUNT_ONE) |=> flag_reg & (cnt_reg == COUNT_RST);
  endproperty
  a_zero: assert property (p_zero) else $error("flag not set at zero");

  property p_req;
    @(posedge pclk) disable iff (!presetn)
    timer_req_reg == (flag_reg & ~mask_reg);
  endproperty
  a_req: assert property (p_req) else $error("request not tied to flag and mask");

  property p_take;
    @(posedge pclk) disable iff (!presetn)
    take_tmr |=> stack_save ##1 vector_fetch ##1 service_run;
  endproperty
  a_take: assert property (p_take) else $error("service sequence broken");

  property p_gmask;
    @(posedge pclk) disable iff (!presetn)
    (seq_reg == SEQ_IDLE) & global_mask |=> ~stack_save & ~ext_take;
  endproperty
  a_gmask: assert property (p_gmask) else $error("taken while masked");

  property p_ext_first;
    @(posedge pclk) disable iff (!presetn)
    decide & ext_irq_pend & treq |=> ext_take & ~stack_save;
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("timer beat external");

  property p_load;
    @(posedge pclk) disable iff (!presetn)
    wr_cnt |=> (cnt_reg == $past(pwdata[7:0]))
      & (presc_reg == PRESC_W'($past(presc_reg) + $past(in_tick)));
  endproperty
  a_load: assert property (p_load) else $error("count load wrong");

  property p_pin_lat;
    @(posedge pclk) disable iff (!presetn)
    USE_EXT_PIN & $rose(pin_s2_reg) |-> $past(timer_pin, 2) & ~$past(timer_pin, 3);
  endproperty
  a_pin_lat: assert property (p_pin_lat) else $error("pin latency not three");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    flag_reg & ~(wr_ctl & ~pwdata[CTL_FLAG]) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped on its own");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
    wr_ctl & ~pwdata[CTL_FLAG] & ~zero_evt |=> ~flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by write");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    step & (cnt_reg == COUNT_RST) |=> &cnt_reg;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to ff");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    ~step & ~wr_cnt |=> $stable(cnt_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a tick");

  property p_mask_wr;
    @(posedge pclk) disable iff (!presetn)
    wr_ctl |=> mask_reg == $past(pwdata[CTL_MASK]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_presc_inc;
    @(posedge pclk) disable iff (!presetn)
    in_tick & ~pclr |=> presc_reg == PRESC_W'($past(presc_reg) + 1'b1);
  endproperty
  a_presc_inc: assert property (p_presc_inc) else $error("prescaler did not advance");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    irq_reg == |(sts_reg & en_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not tied to status and enable");
endmodule : pdt_timer

// ===== sim/pdt_cpu_model.sv
// processor-side model: instruction boundaries and service return
`timescale 1ns/100ps
module pdt_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic service_run,
  output logic insn_end,
  output logic service_done
);
  logic [2:0] tick_reg;
  logic [2:0] run_reg;
  // ==========================
  // instruction every 8 cycles, routine lasts 5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 3'h0;
      run_reg <= 3'h0;
      insn_end <= 1'b0;
      service_done <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 3'h1;
      insn_end <= (tick_reg == 3'h7);
      run_reg <= service_run ? run_reg + 3'h1 : 3'h0;
      service_done <= (run_reg == 3'h4);
    end
  end
endmodule : pdt_cpu_model

// ===== sim/prescaled_down_counter_timer_tb.sv
// self-checking bench for the prescaled down-counter timer
`timescale 1ns/100ps
module prescaled_down_counter_timer_tb;
  import pdt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = DATA_ZERO;
  logic timer_pin = 1'b0;
  logic global_mask = 1'b1;
  logic ext_irq_pend = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, insn_end, service_done, timer_req, ext_take;
  logic stack_save, vector_fetch, service_run, irq, err_seen;
  logic use_ext = 1'b0;
  logic [31:0] prdata_ext;
  logic pready_ext, pslverr_ext;
  wire psel_int = psel & ~use_ext;
  wire psel_ext = psel & use_ext;
  wire [31:0] prdata_m = use_ext ? prdata_ext : prdata;
  wire pready_m = use_ext ? pready_ext : pready;
  wire pslverr_m = use_ext ? pslverr_ext : pslverr;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_stack = 0;
  always #5 pclk = ~pclk;
  pdt_timer #(.USE_EXT_PIN(1'b0), .PRESCALE_SEL(3'd0)) u_pdt_timer (.pclk(pclk),
    .presetn(presetn), .psel(psel_int), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_pin(timer_pin), .insn_end(insn_end), .global_mask(global_mask),
    .ext_irq_pend(ext_irq_pend), .service_done(service_done), .timer_req(timer_req),
    .ext_take(ext_take), .stack_save(stack_save), .vector_fetch(vector_fetch),
    .service_run(service_run), .irq(irq));
  pdt_cpu_model u_pdt_cpu_model (.pclk(pclk), .presetn(presetn),
    .service_run(service_run), .insn_end(insn_end), .service_done(service_done));
  // second build: pin-clocked, divide by four
  pdt_timer #(.USE_EXT_PIN(1'b1), .PRESCALE_SEL(3'd2)) u_pdt_timer_ext (.pclk(pclk),
    .presetn(presetn), .psel(psel_ext), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_ext), .pready(pready_ext), .pslverr(pslverr_ext),
    .timer_pin(timer_pin), .insn_end(insn_end), .global_mask(global_mask),
    .ext_irq_pend(ext_irq_pend), .service_done(service_done), .timer_req(),
    .ext_take(), .stack_save(), .vector_fetch(), .service_run(), .irq());
  // ==========================
  // checking and closing
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge pclk) begin
    cyc++;
    if (stack_save === 1'b1) n_stack++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================
  // apb master, called just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the bench timeout ends this wait
    while (pready_m !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata_m;
    err_seen = pslverr_m;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, idx, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    apb(1'b0, idx, 8'h00, x);
    chk(x, {24'h00_0000, e});
  endtask : rd
  // pin high for k cycles gives k input ticks on the internal build, one on the pin-clocked build
  task automatic ticks(input int k);
    timer_pin <= 1'b1;
    repeat (k) @(posedge pclk);
    timer_pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : ticks
  task automatic wait_for(input bit stk);
    int n;
    n = 0;
    while ((stk ? stack_save : ext_take) !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_for
  // ==========================
  // tests
  initial begin
    int k;
    logic [31:0] x;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_CTL, 8'h77);
    wr(IDX_COUNT, 8'h05);
    rd(IDX_COUNT, 8'h05);
    ticks(3);
    rd(IDX_COUNT, 8'h02);
    rd(IDX_COUNT, 8'h02);
    wr(IDX_COUNT, 8'h20);
    timer_pin <= 1'b1;
    rd(IDX_COUNT, 8'h20);
    rd(IDX_COUNT, 8'h1F);
    timer_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(IDX_COUNT, 8'h1A);
    $display("test count done");
    wr(IDX_CTL, 8'h08);
    rd(IDX_CTL, 8'h37);
    wr(IDX_COUNT, 8'h01);
    rd(IDX_STS, 8'h00);
    ticks(1);
    rd(IDX_COUNT, 8'h00);
    rd(IDX_CTL, 8'hB7);
    chk(timer_req, 1);
    ticks(1);
    rd(IDX_COUNT, 8'hFF);
    rd(IDX_STS, 8'h03);
    wr(IDX_EN, 8'h02);
    repeat (3) @(posedge pclk);
    chk(irq, 1);
    wr(IDX_CLR, 8'h02);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    rd(IDX_STS, 8'h01);
    apb(1'b0, 8'h3F, 8'h00, x);
    chk({x[30:0], err_seen}, 1);
    $display("test zero done");
    wr(IDX_CTL, 8'hC0);
    rd(IDX_CTL, 8'hF7);
    chk(timer_req, 0);
    wr(IDX_CTL, 8'h80);
    repeat (40) @(posedge pclk);
    chk(n_stack, 0);
    chk(timer_req, 1);
    ext_irq_pend <= 1'b1;
    global_mask <= 1'b0;
    k = n_stack;
    wait_for(1'b0);
    chk(ext_take, 1);
    chk(n_stack, k);
    ext_irq_pend <= 1'b0;
    wait_for(1'b1);
    chk(stack_save, 1);
    global_mask <= 1'b1;
    @(posedge pclk);
    chk(vector_fetch, 1);
    @(posedge pclk);
    chk(service_run, 1);
    repeat (12) @(posedge pclk);
    chk(service_run, 0);
    rd(IDX_CTL, 8'hB7);
    $display("test take done");
    wr(IDX_CTL, 8'h00);
    global_mask <= 1'b0;
    k = n_stack;
    repeat (40) @(posedge pclk);
    chk(n_stack, k);
    chk(timer_req, 0);
    global_mask <= 1'b1;
    wr(IDX_COUNT, 8'h01);
    ticks(1);
    rd(IDX_CTL, 8'hB7);
    use_ext <= 1'b1;
    wr(IDX_COUNT, 8'h10);
    wr(IDX_CTL, 8'h48);
    ticks(3);
    repeat (2) ticks(1);
    rd(IDX_COUNT, 8'h10);
    ticks(1);
    rd(IDX_COUNT, 8'h0F);
    use_ext <= 1'b0;
    $display("test pin source done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_CTL, 8'h77);
    $display("test reset done");
    report_and_stop();
  end
endmodule : prescaled_down_counter_timer_tb
